// >>> cpr_core_regs.sv
// Core register set: work registers, status word, stack pointer and stack engine.
// Assumes the instruction decoder issues one command at a time when ready is high.
//
// How it works
// - Code addresses 1FF00-1FFFF of bank 0 are option area, never run.
// - RAM up to FDFF is nine bits; status bit 1 carries the ninth bit.
// - RAM bytes 0 to 7F form 64 two-byte pointer registers of 16 bits.
// - A pointer used for table reads is 17 bits: nine high, eight low.
// - Call stores bank and low PC at SP+1, high nine at SP+2, SP+=2.
// - Primary work register sits at FE00 and resets to zero.
// - Second work register pairs for 16-bit math and tops external addresses.
// - Multiply and divide results spread over all three work registers.
// - Third work register is a signed offset added to a pointer.
// - Carry flag bit 7 follows add carry, subtract borrow and rotate carry.
// - Half carry bit 6 follows carry or borrow out of bit 3, and carry out of bit 11 for word add.
// - Status bits 5 and 4 are free user flags.
// - Status bit 3 picks the code bank for word table reads.
// - Excess flag bit 2 marks signed add or subtract overflow.
// - Excess flag marks nonzero upper product bits in both multiply forms.
// - Excess flag marks division by zero.
// - Status bit 0 always shows odd parity of the primary register.
// - Status word sits at FE06 and resets to zero.
// - Stack pointer bytes sit at FE0A and FE0B and reset to zero.
// - Stack pointer rises before each stack write, falls after each read.
// - Return reads high byte, decrements, reads bank and low, decrements.
// - Unused pointer bytes work as ordinary nine-bit RAM.
`timescale 1ns/1ps
`default_nettype none
module cpr_core_regs (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire cpr_pkg::cpr_cmd_t cmd_i,
    output logic cmd_ready_o,
    output var cpr_pkg::cpr_rsp_t rsp_o,
    output var cpr_pkg::cpr_work_t work_o,
    output logic [7:0] status_o,
    output logic [15:0] stack_ptr_o
);
    import cpr_pkg::*;

    typedef struct packed {
        cpr_work_t w;
        logic [7:0] program_status_word;
        logic [15:0] sp;
        cpr_fsm_t fsm;
        cpr_op_t op;
        logic [1:0] sel;
        logic [8:0] tmp;
        logic [16:0] pc;
        logic bank;
        cpr_rsp_t rsp;
    } cpr_state_t;

    cpr_state_t q;
    cpr_state_t next_q;

    logic [15:0] ram_addr;
    logic ram_we;
    logic [8:0] ram_wdata;
    logic [8:0] ram_rdata;

    logic [7:0] sfr_rd;
    logic [8:0] add_s;
    logic [8:0] sub_s;
    logic [4:0] add_nib;
    logic [16:0] addw_s;
    logic [12:0] addw_lo;
    logic [15:0] ba;
    logic [23:0] mul_s;
    logic [39:0] mul_l;
    logic [15:0] div_d;
    logic [15:0] div_q;
    logic [15:0] div_r;
    logic [15:0] ptr16;
    logic [15:0] c_sext;

    cpr_ram9 u_ram (
        .clk_sys_i(clk_sys_i),
        .clk_en_i(clk_en_i),
        .addr_i(ram_addr),
        .we_i(ram_we),
        .wdata_i(ram_wdata),
        .rdata_o(ram_rdata)
    );

    // Arithmetic datapath from the current registers and the command operand
    always_comb begin
        ba = {q.w.b, q.w.a};
        add_s = {1'b0, q.w.a} + {1'b0, cmd_i.data[7:0]};
        sub_s = {1'b0, q.w.a} - {1'b0, cmd_i.data[7:0]};
        add_nib = {1'b0, q.w.a[3:0]} + {1'b0, cmd_i.data[3:0]};
        addw_s = {1'b0, ba} + {1'b0, cmd_i.data};
        addw_lo = {1'b0, ba[11:0]} + {1'b0, cmd_i.data[11:0]};
        mul_s = {8'h00, ba} * {16'h0000, q.w.c};
        mul_l = {16'h0000, q.w.c, ba} * {24'h000000, cmd_i.data};
        div_d = (q.w.c == 8'h00) ? 16'h0001 : {8'h00, q.w.c};
        div_q = ba / div_d;
        div_r = ba % div_d;
        c_sext = {{8{q.w.c[7]}}, q.w.c};
        ptr16 = {ram_rdata[7:0], q.tmp[7:0]};
        if (cmd_i.addr == ADDR_A) begin
            sfr_rd = q.w.a;
        end else if (cmd_i.addr == ADDR_B) begin
            sfr_rd = q.w.b;
        end else if (cmd_i.addr == ADDR_C) begin
            sfr_rd = q.w.c;
        end else if (cmd_i.addr == ADDR_PSW) begin
            sfr_rd = status_o;
        end else if (cmd_i.addr == ADDR_SPL) begin
            sfr_rd = q.sp[7:0];
        end else if (cmd_i.addr == ADDR_SPH) begin
            sfr_rd = q.sp[15:8];
        end else if (cmd_i.addr > SFR_TOP) begin
            sfr_rd = RSVD_RD;
        end else begin
            sfr_rd = SFR_IDLE_RD;
        end
    end

    always_comb begin
        next_q = q;
        next_q.rsp.done = 1'b0;
        next_q.rsp.opt_fault = 1'b0;
        ram_addr = q.sp;
        ram_we = 1'b0;
        ram_wdata = 9'h000;
        case (q.fsm)
            ST_IDLE: begin
                if (cmd_i.valid) begin
                    next_q.op = cmd_i.op;
                    next_q.sel = cmd_i.sel;
                    next_q.pc = cmd_i.pc;
                    next_q.bank = cmd_i.bank;
                    next_q.rsp.done = 1'b1;
                    case (cmd_i.op)
                        OP_RD: begin
                            ram_addr = cmd_i.addr;
                            if (cmd_i.addr <= RAM_TOP) begin
                                next_q.rsp.rdata = ram_rdata[7:0];
                                next_q.program_status_word[PSW_NINTH] = ram_rdata[8];
                            end else begin
                                next_q.rsp.rdata = sfr_rd;
                            end
                        end
                        OP_WR: begin
                            ram_addr = cmd_i.addr;
                            if (cmd_i.addr <= RAM_TOP) begin
                                ram_we = 1'b1;
                                ram_wdata = {q.program_status_word[PSW_NINTH], cmd_i.data[7:0]};
                            end else if (cmd_i.addr == ADDR_A) begin
                                next_q.w.a = cmd_i.data[7:0];
                            end else if (cmd_i.addr == ADDR_B) begin
                                next_q.w.b = cmd_i.data[7:0];
                            end else if (cmd_i.addr == ADDR_C) begin
                                next_q.w.c = cmd_i.data[7:0];
                            end else if (cmd_i.addr == ADDR_PSW) begin
                                next_q.program_status_word = {cmd_i.data[7:1], 1'b0};
                            end else if (cmd_i.addr == ADDR_SPL) begin
                                next_q.sp[7:0] = cmd_i.data[7:0];
                            end else if (cmd_i.addr == ADDR_SPH) begin
                                next_q.sp[15:8] = cmd_i.data[7:0];
                            end
                        end
                        OP_PUSH: begin
                            ram_addr = q.sp + 16'h0001;
                            ram_we = 1'b1;
                            ram_wdata = {q.program_status_word[PSW_NINTH], cmd_i.data[7:0]};
                            next_q.sp = q.sp + 16'h0001;
                        end
                        OP_POP: begin
                            next_q.rsp.rdata = ram_rdata[7:0];
                            next_q.sp = q.sp - 16'h0001;
                        end
                        OP_CALL: begin
                            ram_addr = q.sp + 16'h0001;
                            ram_we = 1'b1;
                            ram_wdata = {cmd_i.bank, cmd_i.pc[7:0]};
                            next_q.sp = q.sp + 16'h0001;
                            next_q.fsm = ST_SECOND;
                            next_q.rsp.done = 1'b0;
                        end
                        OP_RET: begin
                            next_q.tmp = ram_rdata;
                            next_q.sp = q.sp - 16'h0001;
                            next_q.fsm = ST_SECOND;
                            next_q.rsp.done = 1'b0;
                        end
                        OP_ADD: begin
                            next_q.w.a = add_s[7:0];
                            next_q.program_status_word[PSW_CY] = add_s[8];
                            next_q.program_status_word[PSW_AC] = add_nib[4];
                            next_q.program_status_word[PSW_OV] = (q.w.a[7] == cmd_i.data[7]) && (add_s[7] != q.w.a[7]);
                        end
                        OP_SUB: begin
                            next_q.w.a = sub_s[7:0];
                            next_q.program_status_word[PSW_CY] = sub_s[8];
                            next_q.program_status_word[PSW_AC] = q.w.a[3:0] < cmd_i.data[3:0];
                            next_q.program_status_word[PSW_OV] = (q.w.a[7] != cmd_i.data[7]) && (sub_s[7] != q.w.a[7]);
                        end
                        OP_ADDW: begin
                            {next_q.w.b, next_q.w.a} = addw_s[15:0];
                            next_q.program_status_word[PSW_CY] = addw_s[16];
                            next_q.program_status_word[PSW_AC] = addw_lo[12];
                            next_q.program_status_word[PSW_OV] = (ba[15] == cmd_i.data[15]) && (addw_s[15] != ba[15]);
                        end
                        OP_MUL: begin
                            if (cmd_i.sel[0]) begin
                                next_q.w = {mul_l[7:0], mul_l[15:8], mul_l[23:16]};
                                next_q.program_status_word[PSW_OV] = |mul_l[39:24];
                            end else begin
                                next_q.w = {mul_s[7:0], mul_s[15:8], mul_s[23:16]};
                                next_q.program_status_word[PSW_OV] = |mul_s[23:16];
                            end
                        end
                        OP_DIV: begin
                            if (q.w.c == 8'h00) begin
                                next_q.program_status_word[PSW_OV] = 1'b1;
                            end else begin
                                next_q.w = {div_q[7:0], div_q[15:8], div_r[7:0]};
                                next_q.program_status_word[PSW_OV] = 1'b0;
                            end
                        end
                        OP_ROT: begin
                            {next_q.program_status_word[PSW_CY], next_q.w.a} = {q.w.a, q.program_status_word[PSW_CY]};
                        end
                        OP_PTR: begin
                            ram_addr = {9'h000, cmd_i.data[5:0], 1'b0};
                            next_q.tmp = ram_rdata;
                            next_q.fsm = ST_SECOND;
                            next_q.rsp.done = 1'b0;
                        end
                        OP_EXT: begin
                            next_q.rsp.addr_out = {q.w.b, cmd_i.data};
                        end
                        OP_NOP: begin
                            next_q.rsp.pc = cmd_i.target;
                            next_q.rsp.bank = cmd_i.bank;
                            next_q.rsp.opt_fault = !cmd_i.bank && (cmd_i.target >= OPT_AREA_LO);
                        end
                        default: begin
                            next_q.rsp.done = 1'b0;
                        end
                    endcase
                end
            end
            ST_SECOND: begin
                next_q.fsm = ST_IDLE;
                next_q.rsp.done = 1'b1;
                case (q.op)
                    OP_CALL: begin
                        ram_addr = q.sp + 16'h0001;
                        ram_we = 1'b1;
                        ram_wdata = q.pc[16:8];
                        next_q.sp = q.sp + 16'h0001;
                    end
                    OP_RET: begin
                        next_q.rsp.pc = {q.tmp, ram_rdata[7:0]};
                        next_q.rsp.bank = ram_rdata[8];
                        next_q.rsp.opt_fault = !ram_rdata[8] && ({q.tmp, ram_rdata[7:0]} >= OPT_AREA_LO);
                        next_q.sp = q.sp - 16'h0001;
                    end
                    default: begin
                        ram_addr = {9'h000, q.pc[5:0], 1'b1};
                        if (q.sel == SEL_COFS) begin
                            next_q.rsp.addr_out = {8'h00, ptr16 + c_sext};
                        end else if (q.sel == SEL_TABLE) begin
                            next_q.rsp.addr_out = {6'h00, q.program_status_word[PSW_TBANK], ram_rdata, q.tmp[7:0]};
                        end else begin
                            next_q.rsp.addr_out = {8'h00, ptr16};
                        end
                    end
                endcase
            end
            default: begin
                next_q.fsm = ST_IDLE;
            end
        endcase
        if (q.fsm == ST_IDLE && cmd_i.valid && cmd_i.op == OP_PTR) begin
            next_q.pc = {11'h000, cmd_i.data[5:0]};
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else if (clk_en_i) begin
            q <= next_q;
        end
    end

    assign cmd_ready_o = q.fsm == ST_IDLE;
    assign rsp_o = q.rsp;
    assign work_o = q.w;
    assign status_o = {q.program_status_word[7:1], ^q.w.a};
    assign stack_ptr_o = q.sp;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    logic take;
    assign take = clk_en_i && cmd_ready_o && cmd_i.valid;

    sequence s_take(cpr_op_t o);
        take && cmd_i.op == o;
    endsequence

    sequence s_two_step(cpr_op_t o);
        s_take(o) ##1 clk_en_i;
    endsequence

    a_push_step: assert property (s_take(OP_PUSH) |=> stack_ptr_o == $past(stack_ptr_o) + 16'h0001)
        else $error("push did not raise stack pointer by one");
    a_pop_step: assert property (s_take(OP_POP) |=> stack_ptr_o == $past(stack_ptr_o) - 16'h0001)
        else $error("pop did not lower stack pointer by one");
    a_call_stack: assert property (s_two_step(OP_CALL) |=>
        rsp_o.done && stack_ptr_o == $past(stack_ptr_o, 2) + 16'h0002)
        else $error("call did not advance stack pointer by two");
    a_ret_stack: assert property (s_two_step(OP_RET) |=>
        rsp_o.done && stack_ptr_o == $past(stack_ptr_o, 2) - 16'h0002)
        else $error("return did not lower stack pointer by two");
    a_add_flags: assert property (s_take(OP_ADD) |=>
        status_o[PSW_CY] == $past(add_s[8]) && status_o[PSW_PAR] == ^$past(add_s[7:0]))
        else $error("add carry or parity wrong");
    a_div_zero: assert property (s_take(OP_DIV) ##0 work_o.c == 8'h00 |=>
        status_o[PSW_OV] && work_o == $past(work_o))
        else $error("zero divisor not flagged");
    a_mul_excess: assert property (s_take(OP_MUL) ##0 !cmd_i.sel[0] |=>
        status_o[PSW_OV] == (work_o.c != 8'h00))
        else $error("product excess flag wrong");
    a_ext_addr: assert property (s_take(OP_EXT) |=>
        rsp_o.done && rsp_o.addr_out[23:16] == $past(work_o.b))
        else $error("external address top byte wrong");
    a_opt_fault: assert property (s_take(OP_NOP) ##0 (!cmd_i.bank && cmd_i.target >= OPT_AREA_LO) |=>
        rsp_o.opt_fault)
        else $error("option area target not flagged");
    a_busy_second: assert property (s_take(OP_PTR) |=> !cmd_ready_o ##1 (cmd_ready_o || !$past(clk_en_i)))
        else $error("pointer fetch did not take two steps");

endmodule // cpr_core_regs
`default_nettype wire

// >>> cpr_pkg.sv
// Constants, types and carriers for the CPU core register set and stack.
// Assumes one clock and reset domain shared by every user of the package.
package cpr_pkg;

    // Internal data map
    localparam logic [15:0] ADDR_A = 16'hFE00;
    localparam logic [15:0] ADDR_B = 16'hFE01;
    localparam logic [15:0] ADDR_C = 16'hFE02;
    localparam logic [15:0] ADDR_PSW = 16'hFE06;
    localparam logic [15:0] ADDR_SPL = 16'hFE0A;
    localparam logic [15:0] ADDR_SPH = 16'hFE0B;
    localparam logic [15:0] RAM_TOP = 16'hFDFF;
    localparam logic [15:0] SFR_TOP = 16'hFEFF;
    localparam logic [7:0] SFR_IDLE_RD = 8'h00;
    localparam logic [7:0] RSVD_RD = 8'hFF;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_SP = 16'h0000;

    // Status word bit positions
    localparam int PSW_CY = 7;
    localparam int PSW_AC = 6;
    localparam int PSW_UHI = 5;
    localparam int PSW_ULO = 4;
    localparam int PSW_TBANK = 3;
    localparam int PSW_OV = 2;
    localparam int PSW_NINTH = 1;
    localparam int PSW_PAR = 0;

    // Code space: option area at the top of bank 0
    localparam logic [16:0] OPT_AREA_LO = 17'h1FF00;

    // Implemented 9-bit data RAM
    localparam int RAM_AW = 10;
    localparam logic [15:0] RAM_DEPTH = 16'h0400;
    localparam logic [8:0] RAM_EMPTY_RD = 9'h1FF;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_RD = 4'h1, OP_WR = 4'h2, OP_PUSH = 4'h3,
        OP_POP = 4'h4, OP_CALL = 4'h5, OP_RET = 4'h6, OP_ADD = 4'h7,
        OP_SUB = 4'h8, OP_ADDW = 4'h9, OP_MUL = 4'hA, OP_DIV = 4'hB,
        OP_ROT = 4'hC, OP_PTR = 4'hD, OP_EXT = 4'hE
    } cpr_op_t;

    // Pointer use for OP_PTR; for OP_MUL bit 0 picks the 24x16 form
    localparam logic [1:0] SEL_PLAIN = 2'h0;
    localparam logic [1:0] SEL_COFS = 2'h1;
    localparam logic [1:0] SEL_TABLE = 2'h2;

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SECOND = 2'b01} cpr_fsm_t;

    typedef struct packed {
        logic valid;
        cpr_op_t op;
        logic [1:0] sel;
        logic [15:0] addr;
        logic [15:0] data;
        logic [16:0] pc;
        logic bank;
        logic [16:0] target;
    } cpr_cmd_t;

    typedef struct packed {
        logic done;
        logic [7:0] rdata;
        logic [23:0] addr_out;
        logic [16:0] pc;
        logic bank;
        logic opt_fault;
    } cpr_rsp_t;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } cpr_work_t;

endpackage

// >>> cpr_ram9.sv
// Nine-bit data RAM with combinational read and clocked write.
// Assumes the caller holds the address stable for the cycle; no reset of contents.
`timescale 1ns/1ps
`default_nettype none
module cpr_ram9 (
    input wire logic clk_sys_i,
    input wire logic clk_en_i,
    input wire logic [15:0] addr_i,
    input wire logic we_i,
    input wire logic [8:0] wdata_i,
    output logic [8:0] rdata_o
);
    import cpr_pkg::*;

    logic [8:0] mem [0:(1 << RAM_AW) - 1];
    logic hit;

    // Locations beyond the fitted RAM read as all ones and drop writes
    assign hit = addr_i < RAM_DEPTH;
    assign rdata_o = hit ? mem[addr_i[RAM_AW-1:0]] : RAM_EMPTY_RD;

    always_ff @(posedge clk_sys_i) begin
        if (clk_en_i && we_i && hit) begin
            mem[addr_i[RAM_AW-1:0]] <= wdata_i;
        end
    end

endmodule // cpr_ram9
`default_nettype wire

// >>> test_cpu_core_registers_and_stack.sv
// Self-checking testbench for the core register set and stack engine.
// Assumes cpr_pkg and cpr_core_regs are compiled first; one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_core_registers_and_stack;
    import cpr_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    cpr_cmd_t cmd = '0;
    logic ready;
    cpr_rsp_t rsp;
    cpr_work_t work;
    logic [7:0] st;
    logic [15:0] sp;
    logic flt;
    int err_count = 0;
    int n_compared = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    cpr_core_regs u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .cmd_i(cmd), .cmd_ready_o(ready), .rsp_o(rsp), .work_o(work), .status_o(st),
        .stack_ptr_o(sp));

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // One command, held for one clock edge, then wait a bounded time for done
    task automatic go(input cpr_op_t op, input logic [1:0] sel, input logic [15:0] addr,
                      input logic [15:0] data, input logic [17:0] pcb = '0);
        int n;
        n = 0;
        cmd = '{1'b1, op, sel, addr, data, pcb[16:0], pcb[17], pcb[16:0]};
        @(posedge clk_sys_i);
        #1 cmd.valid = 1'b0;
        while (rsp.done !== 1'b1 && n < 8) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        chk("done", 24'h1, {23'h0, rsp.done});
        flt = rsp.opt_fault;
        // Let one idle edge pass so valid is never lowered and raised in one step
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        go(OP_WR, 2'h0, a, {8'h00, d});
    endtask

    task automatic t_reset;
        chk("work", 24'h0, work);
        chk("status", 24'h0, {16'h0, st});
        chk("sp", 24'h0, {8'h0, sp});
        chk("ready", 24'h1, {23'h0, ready});
    endtask

    task automatic t_regs;
        wr(ADDR_B, 8'h5A);
        go(OP_RD, 2'h0, ADDR_B, 16'h0);
        chk("b read", 24'h5A, {16'h0, rsp.rdata});
        wr(ADDR_PSW, 8'h31);
        chk("psw user bits", 24'h30, {16'h0, st});
        wr(ADDR_PSW, 8'h00);
    endtask

    task automatic t_ram9;
        wr(ADDR_PSW, 8'h02);
        wr(16'h0010, 8'h5A);
        wr(ADDR_PSW, 8'h00);
        wr(16'h0011, 8'h3C);
        go(OP_RD, 2'h0, 16'h0010, 16'h0);
        chk("ram low", 24'h5A, {16'h0, rsp.rdata});
        chk("ninth set", 24'h1, {23'h0, st[1]});
        go(OP_RD, 2'h0, 16'h0011, 16'h0);
        chk("ninth clear", 24'h0, {23'h0, st[1]});
    endtask

    task automatic t_stack;
        wr(ADDR_SPL, 8'h20);
        wr(ADDR_SPH, 8'h01);
        chk("sp bytes", 24'h0120, {8'h0, sp});
        go(OP_PUSH, 2'h0, 16'h0, 16'h0033);
        chk("sp push", 24'h0121, {8'h0, sp});
        go(OP_PUSH, 2'h0, 16'h0, 16'h0044);
        go(OP_POP, 2'h0, 16'h0, 16'h0);
        chk("pop data", 24'h44, {16'h0, rsp.rdata});
        chk("sp pop", 24'h0121, {8'h0, sp});
        go(OP_RD, 2'h0, 16'h0121, 16'h0);
        chk("stack byte", 24'h33, {16'h0, rsp.rdata});
    endtask

    // Clock enable low: a pending push must not move the stack
    task automatic t_freeze;
        logic [15:0] sp0;
        sp0 = sp;
        clk_en_i = 1'b0;
        cmd = '{1'b1, OP_PUSH, 2'h0, 16'h0, 16'h0077, 17'h0, 1'b0, 17'h0};
        repeat (2) @(posedge clk_sys_i);
        #1 chk("sp frozen", {8'h0, sp0}, {8'h0, sp});
        chk("done frozen", 24'h0, {23'h0, rsp.done});
        cmd.valid = 1'b0;
        clk_en_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic t_call;
        wr(ADDR_SPH, 8'h00);
        wr(ADDR_SPL, 8'h40);
        go(OP_CALL, 2'h0, 16'h0, 16'h0, {1'b1, 17'h1ABCD});
        chk("sp call", 24'h0042, {8'h0, sp});
        go(OP_RD, 2'h0, 16'h0041, 16'h0);
        chk("call low", 24'h1CD, {15'h0, st[1], rsp.rdata});
        go(OP_RD, 2'h0, 16'h0042, 16'h0);
        chk("call high", 24'h1AB, {15'h0, st[1], rsp.rdata});
        go(OP_RET, 2'h0, 16'h0, 16'h0);
        chk("ret addr", 24'h3ABCD, {6'h0, rsp.bank, rsp.pc});
        chk("sp ret", 24'h0040, {8'h0, sp});
        chk("ret fault", 24'h0, {23'h0, flt});
        go(OP_CALL, 2'h0, 16'h0, 16'h0, {1'b0, 17'h1FF10});
        go(OP_RET, 2'h0, 16'h0, 16'h0);
        chk("ret option", 24'h1, {23'h0, flt});
        go(OP_NOP, 2'h0, 16'h0, 16'h0, {1'b0, 17'h1FEFF});
        chk("below option", 24'h0, {23'h0, flt});
        go(OP_NOP, 2'h0, 16'h0, 16'h0, {1'b0, OPT_AREA_LO});
        chk("option start", 24'h1, {23'h0, flt});
    endtask

    task automatic t_arith;
        wr(ADDR_PSW, 8'h00);
        wr(ADDR_A, 8'h78);
        go(OP_ADD, 2'h0, 16'h0, 16'h0008);
        chk("add 80", 24'h8045, {8'h0, work.a, st & 8'hC5});
        go(OP_ADD, 2'h0, 16'h0, 16'h0080);
        chk("add 00", 24'h0084, {8'h0, work.a, st & 8'hC5});
        go(OP_SUB, 2'h0, 16'h0, 16'h0001);
        chk("sub ff", 24'hFFC0, {8'h0, work.a, st & 8'hC5});
        wr(ADDR_A, 8'h81);
        wr(ADDR_PSW, 8'h00);
        go(OP_ROT, 2'h0, 16'h0, 16'h0);
        chk("rotate", 24'h0281, {8'h0, work.a, st & 8'h81});
        wr(ADDR_B, 8'h0F);
        wr(ADDR_A, 8'hFF);
        wr(ADDR_PSW, 8'h00);
        go(OP_ADDW, 2'h0, 16'h0, 16'h7001);
        chk("addw", 24'h800044, {work.b, work.a, st & 8'hC5});
    endtask

    task automatic t_muldiv;
        wr(ADDR_A, 8'h34);
        wr(ADDR_B, 8'h12);
        wr(ADDR_C, 8'h10);
        go(OP_MUL, 2'h0, 16'h0, 16'h0);
        chk("mul", 24'h402301, work);
        chk("mul ov", 24'h1, {23'h0, st[2]});
        wr(ADDR_A, 8'h34);
        wr(ADDR_B, 8'h12);
        wr(ADDR_C, 8'h10);
        go(OP_DIV, 2'h0, 16'h0, 16'h0);
        chk("div", 24'h230104, work);
        wr(ADDR_C, 8'h00);
        go(OP_DIV, 2'h0, 16'h0, 16'h0);
        chk("div zero regs", 24'h230100, work);
        chk("div zero ov", 24'h1, {23'h0, st[2]});
        wr(ADDR_A, 8'h03);
        wr(ADDR_B, 8'h02);
        wr(ADDR_C, 8'h01);
        go(OP_MUL, 2'h1, 16'h0, 16'h0100);
        chk("mul long", 24'h000302, work);
        chk("mul long ov", 24'h1, {23'h0, st[2]});
    endtask

    task automatic t_ptr;
        wr(ADDR_PSW, 8'h00);
        wr(16'h0006, 8'h23);
        wr(ADDR_PSW, 8'h02);
        wr(16'h0007, 8'h01);
        wr(ADDR_C, 8'hFF);
        wr(ADDR_PSW, 8'h08);
        go(OP_PTR, SEL_PLAIN, 16'h0, 16'h0003);
        chk("ptr plain", 24'h000123, rsp.addr_out);
        go(OP_PTR, SEL_COFS, 16'h0, 16'h0003);
        chk("ptr offset", 24'h000122, rsp.addr_out);
        go(OP_PTR, SEL_TABLE, 16'h0, 16'h0003);
        chk("ptr table", 24'h030123, {6'h0, rsp.addr_out[17:0]});
        wr(ADDR_B, 8'h5A);
        go(OP_EXT, 2'h0, 16'h0, 16'h1234);
        chk("ext addr", 24'h5A1234, rsp.addr_out);
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        t_reset();
        t_regs();
        t_ram9();
        t_stack();
        t_freeze();
        t_call();
        t_arith();
        t_muldiv();
        t_ptr();
        conclude();
    end
endmodule // test_cpu_core_registers_and_stack
`default_nettype wire
